// ### dbsi_sram_device.sv
// Device end: burst SRAM array behind separate read and write ports
`timescale 1ns/100ps
`default_nettype none
module dbsi_sram_device
  import dbsi_pkg::*;
(
  // Clock, reset and enable
  input  wire logic   i_clock,
  input  wire logic   i_resetn,
  input  wire logic   i_enable,
  // Link to the controller
  dbsi_link_if.device link,
  // Status
  output logic        o_read_active,
  output logic        o_write_active
);

  // Sampled pin bundle: k, read select, write select, pll pin, address, data
  localparam int IN_W = 4 + ADDR_W + WORD_W;
  localparam logic [IN_W-1:0] IN_RESET = {4'h6, {(ADDR_W + WORD_W){1'b0}}};

  logic [IN_W-1:0]   in_meta_reg;
  logic [IN_W-1:0]   in_sync_reg;
  logic              k_prev_reg;
  logic [IN_W-1:0]   pins_in;
  logic              k_s;
  logic              rps_n_s;
  logic              wps_n_s;
  logic              pll_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WORD_W-1:0] d_s;
  logic              edge_seen;
  logic              rise;
  logic              fall;
  logic [SLOT_W-1:0] lat_edges;

  // Pins come from another domain: two flops before anything reads them
  assign pins_in = {link.k, link.rps_n, link.wps_n, link.pll_disable_input, link.addr, link.d};

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      in_meta_reg <= IN_RESET;
      in_sync_reg <= IN_RESET;
      k_prev_reg  <= 1'b0;
    end else if (i_enable) begin
      in_meta_reg <= pins_in;
      in_sync_reg <= in_meta_reg;
      k_prev_reg  <= in_sync_reg[IN_W-1];
    end
  end

  // Field split of the synchronised bundle
  assign k_s     = in_sync_reg[IN_W-1];
  assign rps_n_s = in_sync_reg[IN_W-2];
  assign wps_n_s = in_sync_reg[IN_W-3];
  assign pll_s   = in_sync_reg[IN_W-4];
  assign addr_s  = in_sync_reg[ADDR_W+WORD_W-1:WORD_W];
  assign d_s     = in_sync_reg[WORD_W-1:0];

  // A rise of k is the true clock edge, a fall the complement clock edge
  assign edge_seen = i_enable & (k_s ^ k_prev_reg);
  assign rise      = edge_seen & k_s;
  assign fall      = edge_seen & ~k_s;

  // Latency follows the pll pin level, which is expected to stay static
  assign lat_edges = pll_s ? LAT_EDGES_PLL_ON : LAT_EDGES_PLL_OFF;

  // ---------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------
  dbsi_wr_state_type         wr_state_reg;
  dbsi_wr_state_type         wr_state_next;
  logic [ADDR_W-1:0]         wr_addr_reg;
  logic [IDX_W-1:0]          wr_idx_reg;
  logic                      wr_start;
  logic                      wr_cont;
  logic                      wr_en;
  logic [ADDR_W+IDX_W-1:0]   wr_mem_addr;
  logic [WORD_W-1:0]         mem_array [0:MEM_DEPTH-1];

  // Write address and first word are taken on the complement edge
  assign wr_start    = fall & ~wps_n_s & (wr_state_reg == DBSI_WR_IDLE);
  assign wr_cont     = edge_seen & (wr_state_reg == DBSI_WR_BURST);
  assign wr_en       = wr_start | wr_cont;
  assign wr_mem_addr = wr_start ? dbsi_word_index(addr_s, IDX_FIRST) : dbsi_word_index(wr_addr_reg, wr_idx_reg);

  // Burst sequencer returns to idle after the fourth word
  always_comb begin
    case (wr_state_reg)
      DBSI_WR_IDLE:  wr_state_next = wr_start ? DBSI_WR_BURST : DBSI_WR_IDLE;
      DBSI_WR_BURST: wr_state_next = (wr_cont && wr_idx_reg == IDX_LAST) ? DBSI_WR_IDLE : DBSI_WR_BURST;
      default:       wr_state_next = DBSI_WR_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_state_reg <= DBSI_WR_IDLE;
      wr_addr_reg  <= '0;
      wr_idx_reg   <= IDX_FIRST;
    end else if (i_enable) begin
      wr_state_reg <= wr_state_next;
      if (wr_start) begin
        wr_addr_reg <= addr_s;
        wr_idx_reg  <= IDX_FIRST + 1'b1;
      end else if (wr_cont) begin
        wr_idx_reg <= wr_idx_reg + 1'b1;
      end
    end
  end

  // Each word lands in the array as it arrives, so no write pulse is needed
  always_ff @(posedge i_clock) begin
    if (wr_en) begin
      mem_array[wr_mem_addr] <= d_s;
    end
  end

  // ---------------------------------------------------------------
  // Read port: two slots so a new read can start while a burst drains
  // ---------------------------------------------------------------
  logic                    slot_sel_reg;
  logic                    rd_issue;
  logic [1:0]              slot_valid;
  logic [1:0]              slot_launch;
  logic [ADDR_W-1:0]       slot_addr [2];
  logic [IDX_W-1:0]        slot_word [2];

  // Read address is taken on the true edge only
  assign rd_issue = rise & ~rps_n_s;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_sel_reg <= 1'b0;
    end else if (rd_issue) begin
      slot_sel_reg <= ~slot_sel_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_slot
      logic              valid_reg;
      logic [SLOT_W-1:0] cnt_reg;
      logic [ADDR_W-1:0] addr_reg;
      logic              load;
      logic [SLOT_W-1:0] cnt_step;
      logic [SLOT_W-1:0] lat_end;

      assign load     = rd_issue & (slot_sel_reg == 1'(g));
      assign cnt_step = SLOT_W'(cnt_reg + 1'b1);
      assign lat_end  = SLOT_W'(lat_edges + LAST_WORD_OFS);

      // Word n of the burst leaves on edge latency plus n after the read
      assign slot_launch[g] = valid_reg & edge_seen & (cnt_step >= lat_edges) & (cnt_step <= lat_end);
      assign slot_word[g]   = IDX_W'(cnt_step - lat_edges);
      assign slot_addr[g]   = addr_reg;
      assign slot_valid[g]  = valid_reg;

      always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          valid_reg <= 1'b0;
          cnt_reg   <= '0;
          addr_reg  <= '0;
        end else if (i_enable) begin
          if (load) begin
            valid_reg <= 1'b1;
            cnt_reg   <= '0;
            addr_reg  <= addr_s;
          end else if (valid_reg && edge_seen) begin
            cnt_reg <= cnt_step;
            if (cnt_step == lat_end) begin
              valid_reg <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // Read fetch with bypass of a word being written on the same edge
  logic                    rd_any;
  logic [ADDR_W-1:0]       rd_addr;
  logic [IDX_W-1:0]        rd_word;
  logic [ADDR_W+IDX_W-1:0] rd_mem_addr;
  logic                    rd_fwd;
  logic [WORD_W-1:0]       rd_value;

  assign rd_any      = |slot_launch;
  assign rd_addr     = slot_launch[1] ? slot_addr[1] : slot_addr[0];
  assign rd_word     = slot_launch[1] ? slot_word[1] : slot_word[0];
  assign rd_mem_addr = dbsi_word_index(rd_addr, rd_word);
  assign rd_fwd      = wr_en & (wr_mem_addr == rd_mem_addr);
  assign rd_value    = rd_fwd ? d_s : mem_array[rd_mem_addr];

  // ---------------------------------------------------------------
  // Output registers: echo clocks move on each edge, data with them only on edges that launch a read word
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] q_reg;
  logic              echo_reg;
  logic              echo_n_reg;

  // Single clock mode: the main clock pair also times the outputs
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      q_reg      <= '0;
      echo_reg   <= 1'b0;
      echo_n_reg <= 1'b1;
    end else if (edge_seen) begin
      echo_reg   <= k_s;
      echo_n_reg <= ~k_s;
      if (rd_any) begin
        q_reg <= rd_value;
      end
    end
  end

  // Dedicated read-out pins, never shared with the write-in pins
  assign link.q                 = q_reg;
  assign link.echo_clock_pair   = echo_reg;
  assign link.echo_clock_pair_n = echo_n_reg;

  // Status for the surrounding logic
  assign o_read_active  = |slot_valid;
  assign o_write_active = (wr_state_reg == DBSI_WR_BURST);

endmodule : dbsi_sram_device
`default_nettype wire

// ### dbsi_pkg.sv
// Constants, types and helpers shared by both ends of the burst SRAM link
package dbsi_pkg;

  // Data path shape (x18 organisation, shortened depth)
  localparam int WORD_W    = 18;
  localparam int ADDR_W    = 8;
  localparam int BURST_LEN = 4;
  localparam int IDX_W     = 2;
  localparam int MEM_DEPTH = BURST_LEN << ADDR_W;
  localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
  localparam logic [IDX_W-1:0] IDX_LAST  = 2'h3;

  // Read latency counted in link clock edges (one edge is half a cycle)
  localparam int SLOT_W = 3;
  localparam logic [SLOT_W-1:0] LAT_EDGES_PLL_ON  = 3'h3;
  localparam logic [SLOT_W-1:0] LAT_EDGES_PLL_OFF = 3'h2;
  localparam logic [SLOT_W-1:0] LAST_WORD_OFS     = 3'h3;

  // Link clock made by the controller from the system clock
  localparam int SYS_CLK_MHZ       = 200;
  localparam int LINK_MAX_MHZ      = 333;
  localparam int LINK_MIN_HALF_CYC = (SYS_CLK_MHZ + 2 * LINK_MAX_MHZ - 1) / (2 * LINK_MAX_MHZ);
  // Eight cycles per half leaves room for the two-flop samplers at the far end
  localparam int LINK_HALF_CYC     = (LINK_MIN_HALF_CYC > 8) ? LINK_MIN_HALF_CYC : 8;
  localparam int DIV_W             = 4;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(LINK_HALF_CYC / 2 - 1);
  localparam int EDGE_W = 8;
  localparam logic [EDGE_W-1:0] EDGE_BURST = 8'h04;
  localparam logic [EDGE_W-1:0] EDGE_LAST  = 8'h03;
  localparam logic [EDGE_W-1:0] EDGE_ONE   = 8'h01;

  // Write burst sequencer states, one-hot
  typedef enum logic [1:0] {
    DBSI_WR_IDLE  = 2'h1,
    DBSI_WR_BURST = 2'h2
  } dbsi_wr_state_type;

  // Array index of one word of a burst
  function automatic logic [ADDR_W+IDX_W-1:0] dbsi_word_index(input logic [ADDR_W-1:0] addr,
                                                              input logic [IDX_W-1:0]  idx);
    return {addr, idx};
  endfunction : dbsi_word_index

endpackage : dbsi_pkg

// ### dbsi_link_if.sv
// Link wires between the burst SRAM and its controller
`timescale 1ns/100ps
`default_nettype none
interface dbsi_link_if
  import dbsi_pkg::*;
();
  logic              k;
  logic              rps_n;
  logic              wps_n;
  logic              pll_disable_input;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] d;
  logic [WORD_W-1:0] q;
  logic              echo_clock_pair;
  logic              echo_clock_pair_n;

  modport host (
    output k, rps_n, wps_n, pll_disable_input, addr, d,
    input  q, echo_clock_pair, echo_clock_pair_n
  );

  modport device (
    input  k, rps_n, wps_n, pll_disable_input, addr, d,
    output q, echo_clock_pair, echo_clock_pair_n
  );
endinterface : dbsi_link_if
`default_nettype wire

// ### dbsi_host_ctrl.sv
// Controller end: makes the link clock, issues bursts, captures read data
`timescale 1ns/100ps
`default_nettype none
module dbsi_host_ctrl
  import dbsi_pkg::*;
(
  // Clock, reset, enable and pll disable
  input  wire logic                      i_clock,
  input  wire logic                      i_resetn,
  input  wire logic                      i_enable,
  input  wire logic                      i_pll_disable,
  // Link to the SRAM
  dbsi_link_if.host                      link,
  // Write requests
  input  wire logic                      i_wr_valid,
  input  wire logic [ADDR_W-1:0]         i_wr_addr,
  input  wire logic [BURST_LEN*WORD_W-1:0] i_wr_data,
  output logic                           o_wr_ready,
  // Read requests and returned words
  input  wire logic                      i_rd_valid,
  input  wire logic [ADDR_W-1:0]         i_rd_addr,
  output logic                           o_rd_ready,
  output logic [WORD_W-1:0]              o_rd_data,
  output logic                           o_rd_data_valid,
  output logic                           o_rd_last
);

  // Link clock divider; half period is held well under the speed limit
  logic [DIV_W-1:0]  div_reg;
  logic              k_reg;
  logic [EDGE_W-1:0] edge_cnt_reg;
  logic              tick;
  logic              mid;

  assign tick = i_enable & (div_reg == DIV_LAST);
  assign mid  = i_enable & (div_reg == DIV_MID);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg      <= '0;
      k_reg        <= 1'b0;
      edge_cnt_reg <= '0;
    end else if (i_enable) begin
      div_reg <= tick ? '0 : DIV_W'(div_reg + 1'b1);
      if (tick) begin
        k_reg        <= ~k_reg;
        edge_cnt_reg <= EDGE_W'(edge_cnt_reg + 1'b1);
      end
    end
  end

  // Requests are placed mid-half so the SRAM samples them far from any change
  dbsi_wr_state_type       wr_state_reg;
  logic [BURST_LEN*WORD_W-1:0] wr_buf_reg;
  logic [IDX_W-1:0]        wr_idx_reg;
  logic                    rd_pend_reg;
  logic                    rd_take;
  logic                    wr_take;
  logic                    wr_cont;
  logic [SLOT_W-1:0]       lat_edges;

  assign o_rd_ready = mid & ~k_reg & ~rd_pend_reg;
  assign o_wr_ready = mid & k_reg & (wr_state_reg == DBSI_WR_IDLE);
  assign rd_take    = o_rd_ready & i_rd_valid;
  assign wr_take    = o_wr_ready & i_wr_valid;
  assign wr_cont    = mid & (wr_state_reg == DBSI_WR_BURST);
  assign lat_edges  = i_pll_disable ? LAT_EDGES_PLL_ON : LAT_EDGES_PLL_OFF;

  // Pin drivers; selects are active low and last one half period
  logic              rps_n_reg;
  logic              wps_n_reg;
  logic              pll_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [WORD_W-1:0] d_reg;

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rps_n_reg <= 1'b1;
      wps_n_reg <= 1'b1;
      pll_reg   <= 1'b1;
      addr_reg  <= '0;
      d_reg     <= '0;
    end else if (i_enable) begin
      pll_reg <= i_pll_disable;
      // Both selects are raised at every mid-half, so a read taken while a write select
      // is low (or the reverse) cannot stretch the other select over a second edge
      if (mid) begin
        rps_n_reg <= 1'b1;
        wps_n_reg <= 1'b1;
      end
      if (rd_take) begin
        rps_n_reg <= 1'b0;
        addr_reg  <= i_rd_addr;
      end
      if (wr_take) begin
        wps_n_reg <= 1'b0;
        addr_reg  <= i_wr_addr;
        d_reg     <= i_wr_data[WORD_W-1:0];
      end
      if (wr_cont) begin
        d_reg <= wr_buf_reg[WORD_W*wr_idx_reg +: WORD_W];
      end
    end
  end

  // Write burst: words one to three follow on the next three halves
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_state_reg <= DBSI_WR_IDLE;
      wr_buf_reg   <= '0;
      wr_idx_reg   <= IDX_FIRST;
    end else if (wr_take) begin
      wr_state_reg <= DBSI_WR_BURST;
      wr_buf_reg   <= i_wr_data;
      wr_idx_reg   <= IDX_FIRST + 1'b1;
    end else if (wr_cont) begin
      wr_idx_reg <= wr_idx_reg + 1'b1;
      if (wr_idx_reg == IDX_LAST) begin
        wr_state_reg <= DBSI_WR_IDLE;
      end
    end
  end

  // Read capture: echo clock and data are sampled through two flops each
  logic [WORD_W:0]   rx_meta_reg;
  logic [WORD_W:0]   rx_sync_reg;
  logic              cq_prev_reg;
  logic [EDGE_W-1:0] cq_cnt_reg;
  logic [EDGE_W-1:0] rd_first_reg;
  logic              cq_edge;
  logic [EDGE_W-1:0] cq_cnt_next;
  logic [EDGE_W-1:0] rd_ofs;
  logic              rd_hit;

  assign cq_edge     = i_enable & (rx_sync_reg[WORD_W] ^ cq_prev_reg);
  assign cq_cnt_next = EDGE_W'(cq_cnt_reg + 1'b1);
  assign rd_ofs      = EDGE_W'(cq_cnt_next - rd_first_reg);
  assign rd_hit      = rd_pend_reg & cq_edge & (rd_ofs < EDGE_BURST);

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_meta_reg     <= '0;
      rx_sync_reg     <= '0;
      cq_prev_reg     <= 1'b0;
      cq_cnt_reg      <= '0;
      rd_first_reg    <= '0;
      rd_pend_reg     <= 1'b0;
      o_rd_data       <= '0;
      o_rd_data_valid <= 1'b0;
      o_rd_last       <= 1'b0;
    end else if (i_enable) begin
      rx_meta_reg     <= {link.echo_clock_pair, link.q};
      rx_sync_reg     <= rx_meta_reg;
      cq_prev_reg     <= rx_sync_reg[WORD_W];
      o_rd_data_valid <= rd_hit;
      o_rd_last       <= rd_hit & (rd_ofs == EDGE_LAST);
      if (cq_edge) begin
        cq_cnt_reg <= cq_cnt_next;
      end
      if (rd_take) begin
        rd_pend_reg  <= 1'b1;
        rd_first_reg <= EDGE_W'(edge_cnt_reg + EDGE_ONE + EDGE_W'(lat_edges));
      end else if (rd_hit && rd_ofs == EDGE_LAST) begin
        rd_pend_reg <= 1'b0;
      end
      if (rd_hit) begin
        o_rd_data <= rx_sync_reg[WORD_W-1:0];
      end
    end
  end

  // Link pins
  assign link.k                 = k_reg;
  assign link.rps_n             = rps_n_reg;
  assign link.wps_n             = wps_n_reg;
  assign link.pll_disable_input = pll_reg;
  assign link.addr              = addr_reg;
  assign link.d                 = d_reg;

endmodule : dbsi_host_ctrl
`default_nettype wire

// ### dbsi_link_sva.sv
// Assertions on the link wires between the burst SRAM and its controller
`timescale 1ns/100ps
`default_nettype none
module dbsi_link_sva
  import dbsi_pkg::*;
(
  // Clock and reset
  input wire logic              i_clock,
  input wire logic              i_resetn,
  // Link wires
  input wire logic              k,
  input wire logic              rps_n,
  input wire logic              wps_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              echo_clock_pair,
  input wire logic              echo_clock_pair_n
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);

  // Shapes of one link clock half and of one select pulse
  sequence s_k_high_half;
    k[*8] ##1 !k;
  endsequence
  sequence s_k_low_half;
    !k[*8] ##1 k;
  endsequence
  // Address must not move while a select is low, or the far end may catch a mix
  sequence s_rd_sel_half;
    (!rps_n && $stable(addr))[*7] ##1 rps_n;
  endsequence
  sequence s_wr_sel_half;
    (!wps_n && $stable(addr))[*7] ##1 wps_n;
  endsequence

  // Link clock halves
  a_k_high_time: assert property ($rose(k) |-> s_k_high_half)
    else $error("link clock high half has wrong length");
  a_k_low_time: assert property ($fell(k) |-> s_k_low_half)
    else $error("link clock low half has wrong length");
  // Read select centred on a rise, write select centred on a fall
  a_rd_sel_phase: assert property ($fell(rps_n) |-> (!k)[*4] ##1 $rose(k))
    else $error("read select not centred on a rising link edge");
  a_wr_sel_phase: assert property ($fell(wps_n) |-> k[*4] ##1 $fell(k))
    else $error("write select not centred on a falling link edge");
  a_rd_sel_hold: assert property ($fell(rps_n) |=> s_rd_sel_half)
    else $error("read select or its address not held one half");
  a_wr_sel_hold: assert property ($fell(wps_n) |=> s_wr_sel_half)
    else $error("write select or its address not held one half");
  // Echo pair is complementary and follows the link clock closely
  a_echo_pair_inverse: assert property (echo_clock_pair_n == !echo_clock_pair)
    else $error("echo clock pair not complementary");
  a_echo_rise_track: assert property ($rose(k) |-> ##[1:6] $rose(echo_clock_pair))
    else $error("echo clock did not follow a rising link edge");
  a_echo_fall_track: assert property ($fell(k) |-> ##[1:6] $fell(echo_clock_pair))
    else $error("echo clock did not follow a falling link edge");
endmodule : dbsi_link_sva
`default_nettype wire

// ### dbsi_test.sv
// Self-checking bench: host controller and SRAM device joined on one link
`timescale 1ns/100ps
`default_nettype none
module dbsi_test
  import dbsi_pkg::*;
;
  localparam int BW = BURST_LEN * WORD_W;
  logic              i_clock, i_resetn, i_enable, i_pll_disable;
  logic              i_wr_valid, i_rd_valid, o_wr_ready, o_rd_ready;
  logic [ADDR_W-1:0] i_wr_addr, i_rd_addr, exp_wr_addr, exp_rd_addr;
  logic [BW-1:0]     i_wr_data, exp_wr_data, exp_rd_data;
  logic [WORD_W-1:0] o_rd_data;
  logic              o_rd_data_valid, o_rd_last, o_read_active, o_write_active;
  logic [BW-1:0]     mem [2**ADDR_W];
  bit                written [2**ADDR_W];
  int                fails, n_tests;
  int                seed = 32'h2b45e6c4;

  dbsi_link_if link_if ();
  dbsi_sram_device dbsi_sram_device_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable), .link(link_if.device),
    .o_read_active(o_read_active), .o_write_active(o_write_active));
  dbsi_host_ctrl dbsi_host_ctrl_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_enable(i_enable), .i_pll_disable(i_pll_disable),
    .link(link_if.host), .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .o_wr_ready(o_wr_ready), .i_rd_valid(i_rd_valid), .i_rd_addr(i_rd_addr), .o_rd_ready(o_rd_ready),
    .o_rd_data(o_rd_data), .o_rd_data_valid(o_rd_data_valid), .o_rd_last(o_rd_last));
  dbsi_link_sva dbsi_link_sva_inst (
    .i_clock(i_clock), .i_resetn(i_resetn), .k(link_if.k), .rps_n(link_if.rps_n),
    .wps_n(link_if.wps_n), .addr(link_if.addr), .echo_clock_pair(link_if.echo_clock_pair),
    .echo_clock_pair_n(link_if.echo_clock_pair_n));

  // Word n of a burst, word 0 in the low bits
  function automatic logic [WORD_W-1:0] word_of(input logic [BW-1:0] b, input int n);
    return b[n*WORD_W +: WORD_W];
  endfunction : word_of
  // Read latency in link clock edges: 1.5 cycles with the input high, 1 cycle low
  function automatic int lat_edges(input logic pll);
    return pll ? 3 : 2;
  endfunction : lat_edges

  // Compare tasks, one per kind of value
  task automatic check_word(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_addr(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_addr
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // Write request: hold valid until ready is seen at an edge, then note the burst
  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [BW-1:0] data);
    int cnt;
    @(posedge i_clock);
    i_wr_valid <= 1'b1;
    i_wr_addr  <= a;
    i_wr_data  <= data;
    cnt = 0;
    do begin
      @(posedge i_clock);
      cnt++;
    end while (o_wr_ready !== 1'b1 && cnt < 200);
    i_wr_valid <= 1'b0;
    exp_wr_addr = a;
    exp_wr_data = data;
    mem[a] = data;
    written[a] = 1'b1;
    check_bit("wr_ready", 1'b1, o_wr_ready);
  endtask : do_write

  // Read request, then the four returned words in burst order
  task automatic do_read(input logic [ADDR_W-1:0] a);
    int cnt;
    @(posedge i_clock);
    i_rd_valid <= 1'b1;
    i_rd_addr  <= a;
    cnt = 0;
    do begin
      @(posedge i_clock);
      cnt++;
    end while (o_rd_ready !== 1'b1 && cnt < 200);
    i_rd_valid <= 1'b0;
    exp_rd_addr = a;
    exp_rd_data = mem[a];
    for (int n = 0; n < BURST_LEN; n++) begin
      cnt = 0;
      do begin
        @(posedge i_clock);
        cnt++;
      end while (o_rd_data_valid !== 1'b1 && cnt < 200);
      check_bit("rd_valid", 1'b1, o_rd_data_valid);
      check_word("rd_data", word_of(exp_rd_data, n), o_rd_data);
      check_bit("rd_last", n == BURST_LEN - 1, o_rd_last);
    end
  endtask : do_read

  // Write burst on the wire: address and four words, sampled mid-way between edges
  initial forever begin
    @(negedge link_if.wps_n);
    repeat (2) @(posedge i_clock);
    check_addr("wr_addr", exp_wr_addr, link_if.addr);
    for (int n = 0; n < BURST_LEN; n++) begin
      check_word("d", word_of(exp_wr_data, n), link_if.d);
      if (n == 1) check_bit("write_active", 1'b1, o_write_active);
      // No wait after the last word: a back-to-back write drops its select 32 cycles on
      if (n < BURST_LEN - 1) repeat (8) @(posedge i_clock);
    end
  end

  // Read burst on the wire: each word a fixed number of echo edges after the issue edge
  initial forever begin
    @(negedge link_if.rps_n);
    repeat (2) @(posedge i_clock);
    check_addr("rd_addr", exp_rd_addr, link_if.addr);
    @(posedge link_if.k);
    @(posedge link_if.echo_clock_pair);
    repeat (lat_edges(i_pll_disable)) @(link_if.echo_clock_pair);
    for (int n = 0; n < BURST_LEN; n++) begin
      repeat (2) @(posedge i_clock);
      check_word("q", word_of(exp_rd_data, n), link_if.q);
      if (n == 0) check_bit("read_active", 1'b1, o_read_active);
      if (n < BURST_LEN - 1) @(link_if.echo_clock_pair);
    end
  end

  // System clock, 5 ns period
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Verdict in one place, reached by the tests and by the watchdog
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog: a burst needs under 100 cycles, so this span is ample
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    report_and_stop();
  end

  // Main sequence: corners first, then random concurrent reads and writes, for both latencies
  initial begin
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-1:0] ra;
    logic [BW-1:0]     wd;
    fails = 0;
    n_tests = 0;
    i_resetn <= 1'b0;
    i_enable <= 1'b1;
    i_pll_disable <= 1'b1;
    i_wr_valid <= 1'b0;
    i_wr_addr <= 8'h00;
    i_wr_data <= '0;
    i_rd_valid <= 1'b0;
    i_rd_addr <= 8'h00;
    repeat (12) @(posedge i_clock);
    check_bit("k_reset", 1'b0, link_if.k);
    check_bit("rps_n_reset", 1'b1, link_if.rps_n);
    check_bit("wps_n_reset", 1'b1, link_if.wps_n);
    check_bit("echo_n_reset", 1'b1, link_if.echo_clock_pair_n);
    i_resetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      i_pll_disable <= (p == 0);
      do_write(8'h00, {BW{1'b1}});
      do_write(8'hff, {BW{1'b0}});
      do_read(8'h00);
      wd = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      do_write(8'h5a, wd);
      do_read(8'h5a);
      // Write that lands three halves after a read of the same address: with 3-edge latency
      // each read word leaves on the edge its new value arrives, so the new burst returns
      wd = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      fork
        do_read(8'h5a);
        begin
          @(negedge link_if.rps_n);
          repeat (20) @(posedge i_clock);
          do_write(8'h5a, wd);
          if (p == 0) exp_rd_data = wd;
        end
      join
      for (int i = 0; i < 12; i++) begin
        wa = ADDR_W'($random(seed));
        ra = ADDR_W'($random(seed));
        wd = {8'($random(seed)), 32'($random(seed)), 32'($random(seed))};
        if (!written[ra] || ra == wa) ra = (wa == 8'hff) ? 8'h00 : 8'hff;
        fork
          do_write(wa, wd);
          do_read(ra);
        join
      end
      $display("test with pll_disable_input=%0d done", p == 0);
    end
    report_and_stop();
  end
endmodule : dbsi_test
`default_nettype wire
